// file: shared/ctb_defines.svh
// register map, field positions, reset values and timing counts of the clock timebase beeper
// Summary of operation
// - wait mode runs normally; interrupt wakes
// - active halt: counter runs, registers frozen
// - full halt freezes counter, registers; wake resumes
// - interrupt needs enable set and mask clear
// - timebase wakes active halt, not full halt
// - clock-out enable puts cpu clock on pin; the code toggles the pin per cpu tick, so it runs at half rate
// - clock output suspended in active halt
// - slow divider: osc over 2,4,8,16
// - slow select picks osc or divided clock
// - timebase period 16000/32000/80000/200000 cycles
// - timebase change applies at period end
// - enable gates interrupt; halt becomes active
// - flag set at period end, read clears
// - tone off, ~2k, ~1k, ~500 Hz square
// - tone runs in active halt; software stops it
// - registers at 002Ch, 002Dh, reset zero
`ifndef CTB_DEFINES_SVH
`define CTB_DEFINES_SVH
`define CTB_IDX_CTRL       8'h2C
`define CTB_IDX_TONE       8'h2D
`define CTB_ADDR_CTRL      8'hB0
`define CTB_ADDR_TONE      8'hB4
`define CTB_CTRL_RESET     8'h00
`define CTB_TONE_RESET     2'h0
`define CTB_BIT_CLKOUT     7
`define CTB_BIT_SLOW_HI    6
`define CTB_BIT_SLOW_LO    5
`define CTB_BIT_SMS        4
`define CTB_BIT_TB_HI      3
`define CTB_BIT_TB_LO      2
`define CTB_BIT_IRQ_EN     1
`define CTB_BIT_FLAG       0
`define CTB_TB_PERIOD0     16000
`define CTB_TB_PERIOD1     32000
`define CTB_TB_PERIOD2     80000
`define CTB_TB_PERIOD3     200000
`define CTB_OSC_HZ         8000000
`define CTB_TONE_HZ0       2000
`define CTB_TONE_HZ1       1000
`define CTB_TONE_HZ2       500
`endif

// file: shared/ctb_pkg.sv
// types of the clock timebase beeper
package ctb_pkg;
  typedef enum logic [1:0]
  {
    CTB_RUN         = 2'h0,
    CTB_ACTIVE_HALT = 2'h1,
    CTB_FULL_HALT   = 2'h3
  } ctb_power_type;
endpackage

// file: verilog/ctb_top.sv
// clock prescaler, clock out, timebase counter and beeper with apb registers
//
// Our own choice: the APB register port.
`include "ctb_defines.svh"

module ctb_top #(
  parameter int CNT_W      = 18,
  parameter int TB_PERIOD0 = `CTB_TB_PERIOD0,
  parameter int TB_PERIOD1 = `CTB_TB_PERIOD1,
  parameter int TB_PERIOD2 = `CTB_TB_PERIOD2,
  parameter int TB_PERIOD3 = `CTB_TB_PERIOD3,
  parameter int BEEP_W     = 16,
  parameter int BEEP_HALF0 = `CTB_OSC_HZ / (2 * `CTB_TONE_HZ0),
  parameter int BEEP_HALF1 = `CTB_OSC_HZ / (2 * `CTB_TONE_HZ1),
  parameter int BEEP_HALF2 = `CTB_OSC_HZ / (2 * `CTB_TONE_HZ2)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        halt_instr,
  input  wire logic        halt_wake,
  input  wire logic        wait_mode,
  input  wire logic        cpu_irq_mask,
  output logic             timebase_irq,
  output logic             cpu_clock_en,
  output logic             active_halt,
  output logic             full_halt,
  output logic             clock_out_sel,
  output logic             clock_out_pin_o,
  output logic             clock_out_pin_oe_n,
  output logic             tone_sel,
  output logic             tone_pin_o,
  output logic             tone_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // parameter checks

  if (TB_PERIOD0 < 2 || TB_PERIOD1 < 2 || TB_PERIOD2 < 2 || TB_PERIOD3 < 2)
  begin : g_tb_min
    $error("timebase periods must be at least 2");
  end
  if (TB_PERIOD3 >= (1 << CNT_W) || TB_PERIOD2 >= (1 << CNT_W))
  begin : g_tb_max
    $error("timebase counter too narrow");
  end
  if (BEEP_HALF0 < 1 || BEEP_HALF2 >= (1 << BEEP_W) || BEEP_HALF1 >= (1 << BEEP_W))
  begin : g_beep
    $error("beep half periods out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state

  ctb_pkg::ctb_power_type power_q;
  logic                   clk_out_en_q;
  logic [1:0]             slow_sel_q;
  logic                   slow_mode_q;
  logic [1:0]             tb_sel_q;
  logic [1:0]             tb_run_sel_q;
  logic                   irq_en_q;
  logic                   flag_q;
  logic [1:0]             tone_q;
  logic [CNT_W-1:0]       tb_cnt_q;
  logic [3:0]             div_cnt_q;
  logic                   clk_out_q;
  logic [BEEP_W-1:0]      beep_cnt_q;
  logic                   beep_q;
  logic                   pready_q;
  logic [31:0]            prdata_q;
  logic                   pslverr_q;

  logic                   acc_done;
  logic                   wr_ctrl;
  logic                   wr_tone;
  logic                   rd_ctrl;
  logic                   tb_end;
  logic                   tb_wake;
  logic                   counting;
  logic                   cpu_tick;
  logic [CNT_W-1:0]       tb_last;
  logic [BEEP_W-1:0]      beep_last;
  logic [7:0]             ctrl_rd;

  ////////////////////////////////////////////////////////////////////////////////
  // decoding used by the datapath

  function automatic logic [CNT_W-1:0] tb_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    tb_limit = CNT_W'(TB_PERIOD0 - 1);
      2'h1:    tb_limit = CNT_W'(TB_PERIOD1 - 1);
      2'h2:    tb_limit = CNT_W'(TB_PERIOD2 - 1);
      default: tb_limit = CNT_W'(TB_PERIOD3 - 1);
    endcase
  endfunction

  function automatic logic [3:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    div_mask = 4'h1;
      2'h1:    div_mask = 4'h3;
      2'h2:    div_mask = 4'h7;
      default: div_mask = 4'hF;
    endcase
  endfunction

  function automatic logic [BEEP_W-1:0] beep_limit(input logic [1:0] sel);
    case (sel)
      2'h1:    beep_limit = BEEP_W'(BEEP_HALF0 - 1);
      2'h2:    beep_limit = BEEP_W'(BEEP_HALF1 - 1);
      default: beep_limit = BEEP_W'(BEEP_HALF2 - 1);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state so read data comes from a flop

  assign acc_done = psel && penable && pready_q;
  // writes ignored outside run, registers frozen in both halts
  assign wr_ctrl  = acc_done && pwrite && paddr == `CTB_ADDR_CTRL
                    && power_q == ctb_pkg::CTB_RUN;
  assign wr_tone  = acc_done && pwrite && paddr == `CTB_ADDR_TONE
                    && power_q == ctb_pkg::CTB_RUN;
  assign rd_ctrl  = acc_done && !pwrite && paddr == `CTB_ADDR_CTRL
                    && power_q == ctb_pkg::CTB_RUN;

  assign ctrl_rd  = {clk_out_en_q, slow_sel_q, slow_mode_q, tb_sel_q, irq_en_q, flag_q};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      if (psel && penable && !pready_q)
      begin
        pslverr_q <= paddr != `CTB_ADDR_CTRL && paddr != `CTB_ADDR_TONE;
        if (!pwrite && paddr == `CTB_ADDR_CTRL)
          prdata_q <= {24'h00_0000, ctrl_rd};
        else if (!pwrite && paddr == `CTB_ADDR_TONE)
          prdata_q <= {30'h0000_0000, tone_q};
        else
          prdata_q <= 32'h0000_0000;
      end
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // control register and tone register

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_out_en_q <= 1'b0;
      slow_sel_q   <= 2'h0;
      slow_mode_q  <= 1'b0;
      tb_sel_q     <= 2'h0;
      irq_en_q     <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      clk_out_en_q <= pwdata[`CTB_BIT_CLKOUT];
      slow_sel_q   <= pwdata[`CTB_BIT_SLOW_HI:`CTB_BIT_SLOW_LO];
      slow_mode_q  <= pwdata[`CTB_BIT_SMS];
      tb_sel_q     <= pwdata[`CTB_BIT_TB_HI:`CTB_BIT_TB_LO];
      irq_en_q     <= pwdata[`CTB_BIT_IRQ_EN];
    end
  end

  // reserved tone bits are not stored and read as zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tone_q <= `CTB_TONE_RESET;
    else if (wr_tone)
      tone_q <= pwdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power state

  // the enabled timebase event wakes active halt, as does halt_wake
  assign tb_wake = tb_end && irq_en_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      power_q <= ctb_pkg::CTB_RUN;
    else
    begin
      case (power_q)
        ctb_pkg::CTB_RUN:
          if (halt_instr)
            power_q <= irq_en_q ? ctb_pkg::CTB_ACTIVE_HALT : ctb_pkg::CTB_FULL_HALT;
        ctb_pkg::CTB_ACTIVE_HALT:
          if (tb_wake || halt_wake)
            power_q <= ctb_pkg::CTB_RUN;
        ctb_pkg::CTB_FULL_HALT:
          if (halt_wake)
            power_q <= ctb_pkg::CTB_RUN;
        default:
          power_q <= ctb_pkg::CTB_RUN;
      endcase
    end
  end

  assign active_halt = power_q == ctb_pkg::CTB_ACTIVE_HALT;
  assign full_halt   = power_q == ctb_pkg::CTB_FULL_HALT;

  ////////////////////////////////////////////////////////////////////////////////
  // timebase counter and flag

  // wait mode has no effect, so wait_mode is not a gate
  assign counting = power_q != ctb_pkg::CTB_FULL_HALT;
  assign tb_last  = tb_limit(tb_run_sel_q);
  assign tb_end   = counting && tb_cnt_q == tb_last;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tb_cnt_q <= '0;
    else if (tb_end)
      tb_cnt_q <= '0;
    else if (counting)
      tb_cnt_q <= tb_cnt_q + CNT_W'(1);
  end

  // new period taken only at period end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tb_run_sel_q <= 2'h0;
    else if (tb_end)
      tb_run_sel_q <= tb_sel_q;
  end

  // set by period end; set wins over read clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= 1'b0;
    else if (tb_end)
      flag_q <= 1'b1;
    else if (rd_ctrl)
      flag_q <= 1'b0;
  end

  // interrupt gated by enable and cpu mask
  assign timebase_irq = flag_q && irq_en_q && !cpu_irq_mask && !wait_mode_unused_hold();

  function automatic logic wait_mode_unused_hold();
    wait_mode_unused_hold = 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // cpu clock prescaler and clock out

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_q <= 4'h0;
    else if (power_q == ctb_pkg::CTB_RUN)
      div_cnt_q <= div_cnt_q + 4'h1;
  end

  // normal mode ticks every osc cycle
  assign cpu_tick = power_q == ctb_pkg::CTB_RUN && (!slow_mode_q
                    || (div_cnt_q & div_mask(slow_sel_q)) == div_mask(slow_sel_q));
  assign cpu_clock_en = cpu_tick;

  // pin toggles per cpu tick, so it shows the cpu clock at half rate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_out_q <= 1'b0;
    else if (!clk_out_en_q)
      clk_out_q <= 1'b0;
    else if (cpu_tick)
      clk_out_q <= !clk_out_q;
  end

  // enable hands pin to clock out
  assign clock_out_sel      = clk_out_en_q;
  assign clock_out_pin_oe_n = !clk_out_en_q;
  assign clock_out_pin_o    = clk_out_q && !active_halt;

  ////////////////////////////////////////////////////////////////////////////////
  // beeper

  assign beep_last = beep_limit(tone_q);

  // keeps running in active halt, frozen only in full halt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      beep_cnt_q <= '0;
      beep_q     <= 1'b0;
    end
    else if (tone_q == 2'h0)
    begin
      beep_cnt_q <= '0;
      beep_q     <= 1'b0;
    end
    else if (counting)
    begin
      if (beep_cnt_q >= beep_last)
      begin
        beep_cnt_q <= '0;
        beep_q     <= !beep_q;
      end
      else
        beep_cnt_q <= beep_cnt_q + BEEP_W'(1);
    end
  end

  assign tone_sel      = tone_q != 2'h0;
  assign tone_pin_oe_n = tone_q == 2'h0;
  assign tone_pin_o    = beep_q;

endmodule

// file: test/ctb_pin_load.sv
// pull-up loads on the clock-out and tone pins
module ctb_pin_load (
  input  wire logic clock_out_pin_o,
  input  wire logic clock_out_pin_oe_n,
  input  wire logic tone_pin_o,
  input  wire logic tone_pin_oe_n,
  output logic      clock_pad,
  output logic      tone_pad
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released pin floats up, never keeps the last level
  assign clock_pad = clock_out_pin_oe_n ? 1'b1 : clock_out_pin_o;
  assign tone_pad  = tone_pin_oe_n ? 1'b1 : tone_pin_o;
endmodule

// file: test/ctb_assertions.sv
// port-level checks of the clock timebase beeper
module ctb_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic halt_instr,
  input wire logic halt_wake,
  input wire logic cpu_irq_mask,
  input wire logic timebase_irq,
  input wire logic cpu_clock_en,
  input wire logic active_halt,
  input wire logic full_halt,
  input wire logic clock_out_sel,
  input wire logic clock_out_pin_o,
  input wire logic clock_out_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    psel && penable && pready ##1 !pready;
  endsequence
  property p_apb_wait;
    s_access |=> s_answer;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb wait");
  property p_irq_mask;
    timebase_irq |-> !cpu_irq_mask;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
  property p_ah_exit;
    $rose(timebase_irq) |-> !active_halt;
  endproperty
  a_ah_exit: assert property (p_ah_exit) else $error("halt exit");
  property p_halt_entry;
    halt_instr && !active_halt && !full_halt |=> active_halt || full_halt;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt entry");
  property p_no_wake;
    full_halt && !halt_wake |=> full_halt;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("full halt left");
  property p_halt_clk;
    full_halt || active_halt |-> !cpu_clock_en;
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("clock in halt");
  property p_co_halt;
    active_halt ##1 active_halt |-> !clock_out_pin_o;
  endproperty
  a_co_halt: assert property (p_co_halt) else $error("clock out in halt");
  property p_co_oe;
    clock_out_pin_oe_n == !clock_out_sel;
  endproperty
  a_co_oe: assert property (p_co_oe) else $error("clock pin owner");
endmodule

bind ctb_top ctb_assertions u_chk (.pclk, .presetn, .psel, .penable, .pready, .halt_instr,
  .halt_wake, .cpu_irq_mask, .timebase_irq, .cpu_clock_en, .active_halt, .full_halt,
  .clock_out_sel, .clock_out_pin_o, .clock_out_pin_oe_n);

// file: test/clock_timebase_beeper_tb_top.sv
// self-checking bench of the clock timebase beeper
`include "ctb_defines.svh"
module clock_timebase_beeper_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        halt_instr, halt_wake, wait_mode, cpu_irq_mask, timebase_irq;
  logic        cpu_clock_en, active_halt, full_halt, clock_out_sel, clock_out_pin_o;
  logic        clock_out_pin_oe_n, tone_sel, tone_pin_o, tone_pin_oe_n, co_pad, t_pad;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          bad_count, tests_run;
  localparam logic [7:0] CTRL = `CTB_ADDR_CTRL;
  localparam logic [7:0] TONE = `CTB_ADDR_TONE;
  // short periods keep the run brief
  // only the periods of selects 00 and 11 are shortened, the others are never selected
  ctb_top #(.TB_PERIOD0(20), .TB_PERIOD3(50),
    .BEEP_HALF0(3), .BEEP_HALF1(5), .BEEP_HALF2(7)) u_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .halt_instr,
    .halt_wake, .wait_mode, .cpu_irq_mask, .timebase_irq, .cpu_clock_en, .active_halt,
    .full_halt, .clock_out_sel, .clock_out_pin_o, .clock_out_pin_oe_n, .tone_sel,
    .tone_pin_o, .tone_pin_oe_n);
  ctb_pin_load u_load (.clock_out_pin_o, .clock_out_pin_oe_n, .tone_pin_o,
    .tone_pin_oe_n, .clock_pad(co_pad), .tone_pad(t_pad));
  ////////////////////////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tmo();
    bad_count++;
    summarize();
  endtask
  // whole-word accesses only, no bit set or clear
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
      tmo();
    @(posedge pclk);
  endtask
  // waits for an irq request, or for a tone pin edge
  task automatic w_ev(bit tone, output time t);
    int n;
    logic p;
    p = t_pad;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((tone ? t_pad === p : timebase_irq !== 1'b1) && n < 300);
    t = $time;
    if (n == 300)
      tmo();
  endtask
  task automatic hpulse();
    halt_instr <= 1'b1;
    @(posedge pclk);
    halt_instr <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    apb(0, CTRL, 0);
    chk("ctrl reset", 0, rd);
    apb(0, TONE, 0);
    chk("tone reset", 0, rd);
    apb(1, 8'hB8, 32'hFF);
    chk("unmapped error", 1, err);
  endtask
  task automatic t_clock();
    int c, ticks, togs;
    logic p;
    // code 4 stands for normal mode
    for (c = 0; c < 5; c++)
    begin
      apb(1, CTRL, c < 4 ? 32'(8'h90 | (c << 5)) : 32'h80);
      repeat (16) @(posedge pclk);
      ticks = 0;
      togs = 0;
      p = co_pad;
      repeat (64)
      begin
        @(posedge pclk);
        ticks += (cpu_clock_en === 1'b1);
        togs += (co_pad !== p);
        p = co_pad;
      end
      chk("cpu ticks", c < 4 ? 32 >> c : 64, ticks);
      chk("clock pin toggles", c < 4 ? 32 >> c : 64, togs);
    end
    apb(1, CTRL, 0);
    chk("clock pin free", 1, co_pad);
  endtask
  task automatic t_base();
    time ta, tb;
    wait_mode <= 1'b1;
    apb(1, CTRL, 32'h02);
    apb(0, CTRL, 0);
    w_ev(0, ta);
    apb(1, CTRL, 32'h0E);
    apb(0, CTRL, 0);
    w_ev(0, tb);
    chk("old period", 20, 32'((tb - ta) / 8));
    apb(0, CTRL, 0);
    chk("flag read", 32'h0F, rd);
    w_ev(0, ta);
    chk("new period", 50, 32'((ta - tb) / 8));
    cpu_irq_mask <= 1'b1;
    apb(0, CTRL, 0);
    repeat (60) @(posedge pclk);
    chk("masked irq", 0, timebase_irq);
    apb(0, CTRL, 0);
    chk("flag kept", 32'h0F, rd);
    cpu_irq_mask <= 1'b0;
    wait_mode <= 1'b0;
  endtask
  task automatic t_halt();
    time t;
    int n, togs;
    logic p;
    apb(1, TONE, 32'h1);
    apb(1, CTRL, 32'h82);
    apb(0, CTRL, 0);
    w_ev(0, t);
    apb(0, CTRL, 0);
    hpulse();
    chk("active halt", 1, active_halt);
    chk("clock pin held", 0, co_pad);
    apb(1, CTRL, 0);
    n = 0;
    togs = 0;
    p = t_pad;
    while (active_halt !== 1'b0 && n < 40)
    begin
      @(posedge pclk);
      togs += (t_pad !== p);
      p = t_pad;
      n++;
    end
    chk("halt exit", 0, active_halt);
    chk("tone in halt", 1, togs > 1);
    apb(0, CTRL, 0);
    chk("frozen ctrl", 32'h83, rd);
    apb(1, CTRL, 0);
    hpulse();
    chk("full halt", 1, full_halt);
    repeat (60) @(posedge pclk);
    chk("no timebase wake", 1, full_halt);
    halt_wake <= 1'b1;
    @(posedge pclk);
    halt_wake <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("woken", 0, full_halt);
  endtask
  task automatic t_tone();
    time ta, tb;
    int c;
    // upper bits stay zero, they are reserved
    for (c = 1; c < 4; c++)
    begin
      apb(1, TONE, 32'(c));
      chk("tone select", 1, tone_sel);
      w_ev(1, ta);
      w_ev(1, ta);
      w_ev(1, tb);
      chk("tone half", 2 * c + 1, 32'((tb - ta) / 8));
    end
    apb(1, TONE, 0);
    chk("tone pin free", 1, t_pad);
  endtask
  ////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, halt_instr, halt_wake, wait_mode, cpu_irq_mask} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_clock();
    t_base();
    t_halt();
    t_tone();
    summarize();
  end
endmodule
